// ### core/tcc_top.sv
// Triple comparator digital control, status and APB register slave.
`timescale 1ns/1ns
`default_nettype none
module tcc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [2:0]              analog_raw,
  input  wire logic                    idle_mode,
  output tcc_pkg::tcc_mux_s [2:0]      mux_sel,
  output logic      [2:0]              comparator_out_pin,
  output logic      [2:0]              comparator_out_pin_oe,
  output logic      [2:0]              cmp_trigger,
  output logic                         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  tcc_pkg::tcc_cfg_s [2:0] cfg_reg;
  logic [2:0]  sticky_event_flag_reg;
  logic        idle_irq_suppress_reg;
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [2:0]  sync_prev_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_mask_reg;
  logic [2:0]  compare_result;
  logic [2:0]  fire;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rdata_next;

  // Assemble a control register readback; unimplemented bits stay zero.
  function automatic logic [15:0] ctl_word(input tcc_pkg::tcc_cfg_s c, input logic evt, input logic res);
    logic [15:0] w;
    w = 16'h0000;
    w[tcc_pkg::CTL_ON_BIT]                          = c.comparator_on;
    w[tcc_pkg::CTL_PIN_BIT]                         = c.pin_drive_enable;
    w[tcc_pkg::CTL_INV_BIT]                         = c.result_invert;
    w[tcc_pkg::CTL_EVT_BIT]                         = evt;
    w[tcc_pkg::CTL_RES_BIT]                         = res;
    w[tcc_pkg::CTL_EDGE_HI:tcc_pkg::CTL_EDGE_LO]    = c.event_edge_select;
    w[tcc_pkg::CTL_NONINV_BIT]                      = c.noninv_source_select;
    w[tcc_pkg::CTL_CH_HI:tcc_pkg::CTL_CH_LO]        = c.inv_source_select;
    return w;
  endfunction

  // Control register index for an address, or 3 when it is not a control register.
  function automatic logic [1:0] ctl_index(input logic [11:0] a);
    logic [1:0] i;
    i = 2'h3;
    if (a == tcc_pkg::OFF_CTRL0) begin
      i = 2'h0;
    end else if (a == tcc_pkg::OFF_CTRL1) begin
      i = 2'h1;
    end else if (a == tcc_pkg::OFF_CTRL2) begin
      i = 2'h2;
    end
    return i;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: zero wait states, error on unmapped addresses.
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign hit    = (ctl_index(paddr) != 2'h3) || (paddr == tcc_pkg::OFF_STATUS) ||
                  (paddr == tcc_pkg::OFF_IRQ_STATUS) || (paddr == tcc_pkg::OFF_IRQ_MASK);
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Analog side: disabled comparators are treated as a steady low output.
  // Comparator enable gating.
  always_comb begin
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
      compare_result[i] = cfg_reg[i].comparator_on & (analog_raw[i] ^ cfg_reg[i].result_invert);
    end
  end

  always_comb begin
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
      mux_sel[i].enable     = cfg_reg[i].comparator_on;
      mux_sel[i].noninv_ref = cfg_reg[i].noninv_source_select;
      mux_sel[i].inv_sel    = cfg_reg[i].inv_source_select;
    end
  end

  // The pin path is deliberately unsynchronized so the pad sees the raw decision.
  // Pin drive from raw result.
  assign comparator_out_pin    = compare_result;
  assign comparator_out_pin_oe = {cfg_reg[2].pin_drive_enable, cfg_reg[1].pin_drive_enable,
                                  cfg_reg[0].pin_drive_enable};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronizer and previous value for edge detection.
  // Two-stage synchronizer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg     <= 3'h0;
      sync2_reg     <= 3'h0;
      sync_prev_reg <= 3'h0;
    end else begin
      sync1_reg     <= compare_result;
      sync2_reg     <= sync1_reg;
      sync_prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~sync_prev_reg;
  assign fall = ~sync2_reg & sync_prev_reg;

  // The result already carries the inversion, so a falling raw edge is a rising result edge.
  // Any change mode.
  always_comb begin
    for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
      case (cfg_reg[i].event_edge_select)
        tcc_pkg::EDGE_ANY:  fire[i] = rise[i] | fall[i];
        tcc_pkg::EDGE_FALL: fire[i] = cfg_reg[i].result_invert ? rise[i] : fall[i];
        tcc_pkg::EDGE_RISE: fire[i] = cfg_reg[i].result_invert ? fall[i] : rise[i];
        default:            fire[i] = 1'b0;
      endcase
      fire[i] = fire[i] & ~sticky_event_flag_reg[i];
    end
  end
  assign cmp_trigger = fire;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; only implemented bits are writable.
  // Three control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
        cfg_reg[i] <= '0;
      end
    end else if (wr_en && ctl_index(paddr) != 2'h3 && pstrb[1:0] == 2'h3) begin
      cfg_reg[ctl_index(paddr)].comparator_on        <= pwdata[tcc_pkg::CTL_ON_BIT];
      cfg_reg[ctl_index(paddr)].pin_drive_enable     <= pwdata[tcc_pkg::CTL_PIN_BIT];
      cfg_reg[ctl_index(paddr)].result_invert        <= pwdata[tcc_pkg::CTL_INV_BIT];
      cfg_reg[ctl_index(paddr)].event_edge_select    <= pwdata[tcc_pkg::CTL_EDGE_HI:tcc_pkg::CTL_EDGE_LO];
      cfg_reg[ctl_index(paddr)].noninv_source_select <= pwdata[tcc_pkg::CTL_NONINV_BIT];
      cfg_reg[ctl_index(paddr)].inv_source_select    <= pwdata[tcc_pkg::CTL_CH_HI:tcc_pkg::CTL_CH_LO];
    end
  end

  // Sticky flags: software may write them, but a new event wins over a clear.
  // Sticky event flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_event_flag_reg <= 3'h0;
    end else begin
      for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
        if (fire[i]) begin
          sticky_event_flag_reg[i] <= 1'b1;
        end else if (wr_en && ctl_index(paddr) == i[1:0] && pstrb[1]) begin
          sticky_event_flag_reg[i] <= pwdata[tcc_pkg::CTL_EVT_BIT];
        end
      end
    end
  end

  // Idle suppress bit in the shared status register.
  // Idle suppress storage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_irq_suppress_reg <= 1'b0;
    end else if (wr_en && paddr == tcc_pkg::OFF_STATUS && pstrb[1]) begin
      idle_irq_suppress_reg <= pwdata[tcc_pkg::STS_IDLE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event wins over the clear.
  // Idle interrupt suppression.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= tcc_pkg::IRQ_RESET;
    end else begin
      for (int i = 0; i < tcc_pkg::NUM_CMP; i++) begin
        if (fire[i] && !(idle_mode && idle_irq_suppress_reg)) begin
          irq_status_reg[i] <= 1'b1;
        end else if (wr_en && paddr == tcc_pkg::OFF_IRQ_STATUS && pstrb[0] && pwdata[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= tcc_pkg::IRQ_RESET;
    end else if (wr_en && paddr == tcc_pkg::OFF_IRQ_MASK && pstrb[0]) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // The output is also held off in suppressed idle so pending bits do not wake the core.
  assign irq = |(irq_status_reg & irq_mask_reg) && !(idle_mode && idle_irq_suppress_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Read data is registered in the setup phase and valid in the access phase.
  // Event mirrors.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ctl_index(paddr) != 2'h3) begin
      rdata_next[15:0] = ctl_word(cfg_reg[ctl_index(paddr)], sticky_event_flag_reg[ctl_index(paddr)],
                                  sync2_reg[ctl_index(paddr)]);
    end else if (paddr == tcc_pkg::OFF_STATUS) begin
      rdata_next[tcc_pkg::STS_IDLE_BIT]                     = idle_irq_suppress_reg;
      rdata_next[tcc_pkg::STS_EVT_LO+2:tcc_pkg::STS_EVT_LO] = sticky_event_flag_reg;
      rdata_next[tcc_pkg::STS_RES_LO+2:tcc_pkg::STS_RES_LO] = sync2_reg;
    end else if (paddr == tcc_pkg::OFF_IRQ_STATUS) begin
      rdata_next[2:0] = irq_status_reg;
    end else if (paddr == tcc_pkg::OFF_IRQ_MASK) begin
      rdata_next[2:0] = irq_mask_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  AST_SYNC_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    sync2_reg == $past(compare_result, 2)) else $error("synchronizer is not two stages");
  AST_OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !cfg_reg[0].comparator_on |-> !compare_result[0]) else $error("disabled comparator shows output");
  AST_PIN_OE: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_out_pin_oe[1] == cfg_reg[1].pin_drive_enable && comparator_out_pin[1] == compare_result[1])
    else $error("pin drive mismatch");
  AST_STICKY_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    sticky_event_flag_reg[0] |-> !cmp_trigger[0]) else $error("trigger while flag set");
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] |=> sticky_event_flag_reg[0]) else $error("event flag not set");
  AST_NONE_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[1].event_edge_select == tcc_pkg::EDGE_NONE |-> !cmp_trigger[1]) else $error("event in disabled mode");
  AST_RISE_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] && cfg_reg[0].event_edge_select == tcc_pkg::EDGE_RISE && !cfg_reg[0].result_invert
    |-> sync2_reg[0] && !sync_prev_reg[0]) else $error("wrong edge in rising mode");
  AST_FALL_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] && cfg_reg[0].event_edge_select == tcc_pkg::EDGE_FALL && !cfg_reg[0].result_invert
    |-> !sync2_reg[0] && sync_prev_reg[0]) else $error("wrong edge in falling mode");
  AST_ANY_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[0].event_edge_select == tcc_pkg::EDGE_ANY && !sticky_event_flag_reg[0] && $changed(sync2_reg[0])
    |-> cmp_trigger[0]) else $error("change missed in any mode");
  AST_IDLE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    idle_mode && idle_irq_suppress_reg |-> !irq) else $error("interrupt in suppressed idle");
  AST_STATUS_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_STATUS |=> prdata[10:8] == $past(sticky_event_flag_reg)
    && prdata[2:0] == $past(sync2_reg) && prdata[14:11] == 4'h0) else $error("status mirror wrong");
  AST_CTL_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_CTRL0 |=> (prdata & ~32'h0000_E3D3) == 32'h0000_0000)
    else $error("reserved control bits not zero");

  // Register file: each control register is written only through its own address.
  AST_CTL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == tcc_pkg::OFF_CTRL1 && pstrb[1:0] == 2'h3
    |=> cfg_reg[1].comparator_on == $past(pwdata[tcc_pkg::CTL_ON_BIT])) else $error("control write lost");
  AST_CTL_NO_CROSS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == tcc_pkg::OFF_CTRL1 |=> cfg_reg[0] == $past(cfg_reg[0]) && cfg_reg[2] == $past(cfg_reg[2]))
    else $error("control write reached another comparator");
  AST_CTL_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_CTRL2 |=> prdata[31:16] == 16'h0000 && prdata[12:10] == 3'h0
    && prdata[5] == 1'b0 && prdata[3:2] == 2'h0) else $error("control reserved bits set");
  AST_STATUS_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_STATUS |=> prdata[31:16] == 16'h0000 && prdata[7:3] == 5'h00)
    else $error("status reserved bits set");

  // Reset leaves every register cleared at the first edge after release.
  AST_RESET_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> cfg_reg[0] == '0 && cfg_reg[1] == '0 && cfg_reg[2] == '0
    && sticky_event_flag_reg == 3'h0 && !idle_irq_suppress_reg && !irq) else $error("register not cleared");

  // Result path: polarity and readback of the synchronized result.
  AST_INV_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[0].comparator_on |-> compare_result[0] == (analog_raw[0] ^ cfg_reg[0].result_invert))
    else $error("result polarity wrong");
  AST_RESULT_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_CTRL0 |=> prdata[8] == $past(sync2_reg[0]))
    else $error("result bit readback wrong");
  AST_EVT_READ: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == tcc_pkg::OFF_CTRL0 |=> prdata[9] == $past(sticky_event_flag_reg[0]))
    else $error("event bit readback wrong");

  // Analog mux control follows the configuration.
  AST_MUX_ON: assert property (@(posedge pclk) disable iff (!presetn)
    mux_sel[1].enable == cfg_reg[1].comparator_on) else $error("mux enable wrong");
  AST_MUX_NONINV: assert property (@(posedge pclk) disable iff (!presetn)
    mux_sel[1].noninv_ref == cfg_reg[1].noninv_source_select) else $error("noninverting source wrong");
  AST_MUX_INV: assert property (@(posedge pclk) disable iff (!presetn)
    mux_sel[1].inv_sel == cfg_reg[1].inv_source_select) else $error("inverting source wrong");

  // Edge qualification in inverted polarity and for any trigger.
  AST_INV_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] && cfg_reg[0].event_edge_select == tcc_pkg::EDGE_RISE && cfg_reg[0].result_invert
    |-> !sync2_reg[0] && sync_prev_reg[0]) else $error("wrong edge in inverted rising mode");
  AST_INV_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] && cfg_reg[0].event_edge_select == tcc_pkg::EDGE_FALL && cfg_reg[0].result_invert
    |-> sync2_reg[0] && !sync_prev_reg[0]) else $error("wrong edge in inverted falling mode");
  AST_TRIG_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[1] |-> sync2_reg[1] != sync_prev_reg[1]) else $error("trigger without a change");

  // Interrupt status capture outside and inside suppressed idle.
  AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[0] && !idle_mode |=> irq_status_reg[0]) else $error("interrupt status not set");
  AST_IDLE_NO_SET: assert property (@(posedge pclk) disable iff (!presetn)
    idle_mode && idle_irq_suppress_reg && !irq_status_reg[0] |=> !irq_status_reg[0])
    else $error("interrupt status set in suppressed idle");
  AST_IRQ_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_status_reg & irq_mask_reg) == 3'h0 |-> !irq) else $error("interrupt without pending bit");

  COV_EVENT: cover property (@(posedge pclk) disable iff (!presetn) cmp_trigger[0]);
  COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) irq);
  COV_INV_RISE: cover property (@(posedge pclk) disable iff (!presetn)
    cmp_trigger[1] && cfg_reg[1].result_invert);
  COV_IDLE_BLOCK: cover property (@(posedge pclk) disable iff (!presetn)
    irq_status_reg[0] && irq_mask_reg[0] && idle_mode && idle_irq_suppress_reg);

endmodule
`default_nettype wire

// ### shared/tcc_pkg.sv
// Package with register map, field positions and carrier types for the triple comparator control block.
`default_nettype none
package tcc_pkg;
  localparam int          NUM_CMP         = 3;
  localparam logic [11:0] OFF_CTRL0       = 12'h000;
  localparam logic [11:0] OFF_CTRL1       = 12'h004;
  localparam logic [11:0] OFF_CTRL2       = 12'h008;
  localparam logic [11:0] OFF_STATUS      = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h014;
  localparam int          CTL_ON_BIT      = 15;
  localparam int          CTL_PIN_BIT     = 14;
  localparam int          CTL_INV_BIT     = 13;
  localparam int          CTL_EVT_BIT     = 9;
  localparam int          CTL_RES_BIT     = 8;
  localparam int          CTL_EDGE_HI     = 7;
  localparam int          CTL_EDGE_LO     = 6;
  localparam int          CTL_NONINV_BIT  = 4;
  localparam int          CTL_CH_HI       = 1;
  localparam int          CTL_CH_LO       = 0;
  localparam int          STS_IDLE_BIT    = 15;
  localparam int          STS_EVT_LO      = 8;
  localparam int          STS_RES_LO      = 0;
  localparam logic [15:0] CTL_WR_MASK     = 16'hE0D3;
  localparam logic [15:0] CTL_RESET       = 16'h0000;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;
  localparam logic [1:0]  EDGE_NONE       = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_ANY        = 2'h3;
  localparam logic [1:0]  CH_PIN_B        = 2'h0;
  localparam logic [1:0]  CH_PIN_C        = 2'h1;
  localparam logic [1:0]  CH_PIN_D        = 2'h2;
  localparam logic [1:0]  CH_HALF_BG      = 2'h3;

  // Per-comparator configuration as software wrote it.
  typedef struct packed {
    logic       comparator_on;
    logic       pin_drive_enable;
    logic       result_invert;
    logic [1:0] event_edge_select;
    logic       noninv_source_select;
    logic [1:0] inv_source_select;
  } tcc_cfg_s;

  // Analog source selection handed to the analog front end.
  typedef struct packed {
    logic       enable;
    logic       noninv_ref;
    logic [1:0] inv_sel;
  } tcc_mux_s;
endpackage
`default_nettype wire

// ### verif/test_triple_comparator_control.sv
// Self-checking testbench for the triple comparator control block.
`timescale 1ns/1ns
`default_nettype none
module test_triple_comparator_control;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [11:0]             paddr;
  logic [31:0]             pwdata;
  logic [3:0]              pstrb;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic [2:0]              analog_raw;
  logic                    idle_mode;
  tcc_pkg::tcc_mux_s [2:0] mux_sel;
  logic [2:0]              comparator_out_pin;
  logic [2:0]              comparator_out_pin_oe;
  logic [2:0]              cmp_trigger;
  logic                    irq;
  logic [33:0]             exp_q[$];
  logic [33:0]             ent;
  logic [31:0]             rnd;
  logic [1:0]              m;
  logic                    n;
  int                      fails;
  int                      total_checks;
  int                      trig_cnt;
  int                      t0;

  tcc_top i_tcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_raw(analog_raw), .idle_mode(idle_mode), .mux_sel(mux_sel), .comparator_out_pin(comparator_out_pin),
    .comparator_out_pin_oe(comparator_out_pin_oe), .cmp_trigger(cmp_trigger), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 10 ns.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Comparison shared by the monitor and the main sequence.
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One APB transfer; the expected answer is noted before the request goes out.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [15:0] e,
                     input logic err);
    exp_q.push_back({wr, err, 16'h0000, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: each completed transfer is matched against the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      ent = exp_q.pop_front();
      chk("pslverr", {31'h0, ent[32]}, {31'h0, pslverr});
      if (!ent[33]) chk("prdata", ent[31:0], prdata);
    end
  end

  // Counts trigger pulses of comparator 0; a pulse stands one cycle only.
  always @(posedge pclk) begin
    if (cmp_trigger[0] === 1'b1) trig_cnt <= trig_cnt + 1;
  end

  // The whole sequence needs a few hundred cycles, so this limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    analog_raw = 3'h0;
    idle_mode = 1'b0;
    rnd = 32'h06BA;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) apb(1'b0, 12'(i * 4), 16'h0, 16'h0, 1'b0);
    apb(1'b0, 12'h018, 16'h0, 16'h0, 1'b1);
    apb(1'b1, 12'h018, 16'hFFFF, 16'h0, 1'b1);
    chk("irq_reset", 32'h0, {31'h0, irq});
    // unimplemented bits read zero; comparators stay off so results stay zero.
    for (int i = 0; i < 9; i++) begin
      rnd = xs(rnd);
      apb(1'b1, 12'(4 * (i % 3)), rnd[15:0] & 16'h7FFF, 16'h0, 1'b0);
      apb(1'b0, 12'(4 * (i % 3)), 16'h0, rnd[15:0] & 16'h62D3, 1'b0);
    end
    for (int i = 0; i < 3; i++) apb(1'b1, 12'(4 * i), 16'h0, 16'h0, 1'b0);
    apb(1'b1, tcc_pkg::OFF_STATUS, 16'hFFFF, 16'h0, 1'b0);
    apb(1'b0, tcc_pkg::OFF_STATUS, 16'h0, 16'h8000, 1'b0);
    apb(1'b1, tcc_pkg::OFF_STATUS, 16'h0, 16'h0, 1'b0);
    // every source selection reaches the analog mux.
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, tcc_pkg::OFF_CTRL1, {11'h400, i[2], 2'b00, i[1:0]}, 16'h0, 1'b0);
      @(negedge pclk);
      chk("mux_sel", {28'h0, 1'b1, i[2], i[1:0]}, {28'h0, mux_sel[1]});
    end
    // all three results mirrored in the status register.
    @(posedge pclk) analog_raw <= 3'b101;
    for (int i = 0; i < 3; i++) apb(1'b1, 12'(4 * i), 16'h8000, 16'h0, 1'b0);
    repeat (4) @(posedge pclk);
    apb(1'b0, tcc_pkg::OFF_STATUS, 16'h0, 16'h0005, 1'b0);
    apb(1'b0, tcc_pkg::OFF_CTRL2, 16'h0, 16'h8100, 1'b0);
    // pin shows the raw result with polarity applied.
    for (int v = 0; v < 4; v++) begin
      @(posedge pclk) analog_raw <= {2'b00, v[0]};
      apb(1'b1, tcc_pkg::OFF_CTRL0, {2'b11, v[1], 13'h0}, 16'h0, 1'b0);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("pin", {31'h0, v[0] ^ v[1]}, {31'h0, comparator_out_pin[0]});
      chk("pin_oe", 32'h1, {31'h0, comparator_out_pin_oe[0]});
      apb(1'b0, tcc_pkg::OFF_CTRL0, 16'h0, {2'b11, v[1], 4'h0, v[0] ^ v[1], 8'h0}, 1'b0);
    end
    apb(1'b1, tcc_pkg::OFF_CTRL0, 16'h0, 16'h0, 1'b0);
    @(negedge pclk);
    chk("pin_off", 32'h0, {30'h0, comparator_out_pin_oe[0], comparator_out_pin[0]});
    // every edge mode in both polarities, then a second edge under a set flag.
    for (int k = 0; k < 8; k++) begin
      m = k[1:0];
      n = k[2];
      @(posedge pclk) analog_raw[0] <= 1'b0;
      apb(1'b1, tcc_pkg::OFF_CTRL0, {2'b10, n, 13'h0}, 16'h0, 1'b0);
      repeat (4) @(posedge pclk);
      apb(1'b1, tcc_pkg::OFF_CTRL0, {2'b10, n, 5'h0, m, 6'h0}, 16'h0, 1'b0);
      t0 = trig_cnt;
      @(posedge pclk) analog_raw[0] <= 1'b1;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk("rise_trig", {31'h0, m[0]}, 32'(trig_cnt - t0));
      apb(1'b0, tcc_pkg::OFF_CTRL0, 16'h0, {2'b10, n, 3'h0, m[0], ~n, m, 6'h0}, 1'b0);
      apb(1'b0, tcc_pkg::OFF_STATUS, 16'h0, {7'h0, m[0], 7'h0, ~n}, 1'b0);
      t0 = trig_cnt;
      @(posedge pclk) analog_raw[0] <= 1'b0;
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      chk("fall_trig", {31'h0, m[1] & ~m[0]}, 32'(trig_cnt - t0));
    end
    // sticky interrupt status, mask, idle suppression and clearing.
    apb(1'b0, tcc_pkg::OFF_IRQ_STATUS, 16'h0, 16'h0001, 1'b0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, tcc_pkg::OFF_IRQ_MASK, 16'h0001, 16'h0, 1'b0);
    @(negedge pclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, tcc_pkg::OFF_STATUS, 16'h8000, 16'h0, 1'b0);
    @(posedge pclk) idle_mode <= 1'b1;
    @(negedge pclk);
    chk("irq_idle", 32'h0, {31'h0, irq});
    apb(1'b1, tcc_pkg::OFF_STATUS, 16'h0, 16'h0, 1'b0);
    @(negedge pclk);
    chk("irq_idle_run", 32'h1, {31'h0, irq});
    apb(1'b1, tcc_pkg::OFF_IRQ_STATUS, 16'h0001, 16'h0, 1'b0);
    @(negedge pclk);
    chk("irq_clear", 32'h0, {31'h0, irq});
    apb(1'b0, tcc_pkg::OFF_IRQ_STATUS, 16'h0, 16'h0000, 1'b0);
    @(posedge pclk) idle_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    final_report();
  end
endmodule
`default_nettype wire
